/* File: inc/slk_pkg.sv */
`default_nettype none
package slk_pkg;
  // bus shape
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  // sector array shape
  localparam int NUM_SECT = 32;
  localparam int SECT_W   = 5;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CMD     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OPND_LO = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OPND_HI = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PBITS   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_VBITS   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_UNPROT  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PWD_LO  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_PWD_HI  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_RADDR   = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CONFIG  = 8'h28;
  // command register fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_OP_W     = 4;
  localparam int CMD_SECT_LSB = 8;
  localparam int CMD_VAL_BIT  = 16;
  localparam int CFG_RDPROT_BIT = 0;
  // protection mode field
  localparam int MODE_W = 2;
  localparam logic [MODE_W-1:0] MODE_BLANK   = 2'h3;
  localparam logic [MODE_W-1:0] MODE_PERSIST = 2'h2;
  localparam logic [MODE_W-1:0] MODE_PASSWD  = 2'h1;
  localparam logic [MODE_W-1:0] MODE_ILLEGAL = 2'h0;
  localparam int MODE_PW_BIT = 1;
  // password store
  localparam int PWD_W = 64;
  localparam logic [PWD_W-1:0] PWD_ERASED = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [NUM_SECT-1:0] SECT_ALL_ONES = 32'hFFFF_FFFF;
  // forced read address while read protection is on
  localparam logic [DATA_W-1:0] BOOT_ADDR = 32'h0000_0000;
  // unlock rate limit
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int UNLOCK_WAIT_NS  = 100000;
  localparam int UNLOCK_TOL_NS   = 20000;
  localparam int UNLOCK_WAIT_CYC = UNLOCK_WAIT_NS * 1000 / CLK_PERIOD_PS;
  localparam int CNT_W = 16;
  // commands
  typedef enum logic [CMD_OP_W-1:0] {
    OP_NOP        = 4'h0,
    OP_LOCK_CLR   = 4'h1,
    OP_UNLOCK     = 4'h2,
    OP_PWD_PROG   = 4'h3,
    OP_PWD_READ   = 4'h4,
    OP_PBIT_PROG  = 4'h5,
    OP_PBIT_ERASE = 4'h6,
    OP_VBIT_WR    = 4'h7,
    OP_MODE_PROG  = 4'h8,
    OP_SOFT_RST   = 4'h9,
    OP_CLR_ERR    = 4'hA
  } slk_op_t;
  // sequencer
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_HOLD = 1'b1
  } slk_state_t;
  // status word, busy in bit 0
  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic              read_prot;
    logic              lock;
    logic              perr;
    logic              busy;
  } slk_status_t;
endpackage
`default_nettype wire

/* File: design/slk_sector_lock.sv */
// How it works
// - one volatile lock bit; 0 freezes persistent sector bits, 1 frees them
// - lock clear command drops the lock bit to 0
// - persistent mode sets lock to 1 at power-on and hardware reset
// - persistent mode has no command that sets lock back to 1
// - password mode clears lock to 0 at power-on and hardware reset
// - in password mode only a good unlock sets the lock bit
// - software reset leaves the lock bit alone
// - sector unprotected only when persistent and volatile bits are both 1
// - lock at 0 still lets volatile bits change
// - any reset returns every volatile sector bit to 1
// - persistent bits survive hardware and software reset
// - password is 64 bits, every value valid
// - password program only clears bits, no error on 1 over 0
// - password sits apart, erased to all ones, own commands only
// - password mode makes password read and program be ignored
// - wrong password sets error, keeps busy, leaves lock alone
// - unlock accepted at most once per 100 us, busy held meanwhile
// - matching password skips the wait and clears busy at once
// - protection mode bits are one-time programmable, never erased
// - read protection forces read address to the boot sector
// - persistent program or erase with lock 0 fails, bits unchanged
// - mode 10 persistent, 01 password, blank 11 acts as persistent
// - volatile write sets a sector bit to 0 or 1 freely
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module slk_sector_lock #(
  parameter int unsigned UNLOCK_CYC = slk_pkg::UNLOCK_WAIT_CYC
) (
  // clock, reset, enable
  input  wire logic                           mclk,
  input  wire logic                           arst_n,
  input  wire logic                           clk_en,
  // hardware reset pin, asynchronous
  input  wire logic                           hw_reset_n,
  // register port
  input  wire logic [slk_pkg::ADDR_W-1:0]     reg_addr,
  input  wire logic [slk_pkg::DATA_W-1:0]     reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [slk_pkg::DATA_W-1:0]     reg_rdata,
  // protection state
  output logic                                lock,
  output logic                                busy,
  output logic      [slk_pkg::NUM_SECT-1:0]   unprot_map
);

  // pin synchroniser
  logic                          hr_meta;
  logic                          hr_sync;
  logic                          hw_rst;

  // sequencer
  slk_pkg::slk_state_t           state;
  logic [slk_pkg::CNT_W-1:0]     wait_cnt;
  logic                          unlock_ok;

  // stored state
  logic                          perr;
  logic                          read_prot;
  logic [slk_pkg::MODE_W-1:0]    mode;
  logic [slk_pkg::PWD_W-1:0]     pwd;
  logic [slk_pkg::PWD_W-1:0]     pwd_rd;
  logic [slk_pkg::PWD_W-1:0]     opnd;
  logic [slk_pkg::NUM_SECT-1:0]  pbits;
  logic [slk_pkg::NUM_SECT-1:0]  vbits;
  logic [slk_pkg::DATA_W-1:0]    raddr;

  // decoded command
  logic                          cmd_go;
  slk_pkg::slk_op_t              op;
  logic [slk_pkg::SECT_W-1:0]    sect;
  logic                          sval;
  logic                          pw_mode;
  logic                          pwd_match;
  logic [slk_pkg::MODE_W-1:0]    mode_new;
  logic                          mode_ok;
  logic                          wr_go;
  logic                          rd_go;
  slk_pkg::slk_status_t          status;

  // hardware reset pin crosses into mclk
  // flops start high, the pin's idle level, so power-on shows no false reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hr_meta <= 1'b1;
      hr_sync <= 1'b1;
    end else if (clk_en) begin
      hr_meta <= hw_reset_n;
      hr_sync <= hr_meta;
    end
  end

  // reset level held while the pin is low
  assign hw_rst = ~hr_sync;

  // bus strobes qualified by the enable
  // with the enable low a strobe is lost, not delayed
  assign wr_go = clk_en & reg_wr;
  assign rd_go = clk_en & reg_rd;

  // commands are refused while busy or in hardware reset
  assign cmd_go = wr_go & (reg_addr == slk_pkg::OFS_CMD) & (state == slk_pkg::ST_IDLE) & ~hw_rst;
  assign op     = slk_pkg::slk_op_t'(reg_wdata[slk_pkg::CMD_OP_LSB +: slk_pkg::CMD_OP_W]);
  assign sect   = reg_wdata[slk_pkg::CMD_SECT_LSB +: slk_pkg::SECT_W];
  assign sval   = reg_wdata[slk_pkg::CMD_VAL_BIT];

  // mode decode
  // blank and persistent both keep the password bit at 1
  assign pw_mode = ~mode[slk_pkg::MODE_PW_BIT];

  // full-width compare
  // all 64 bits in one comparator, no partial match leaks out
  assign pwd_match = (opnd == pwd);

  // one-time mode bits
  // programming can only clear bits, and only from the blank state
  assign mode_new = mode & opnd[slk_pkg::MODE_W-1:0];
  assign mode_ok  = (mode == slk_pkg::MODE_BLANK) && (mode_new != slk_pkg::MODE_ILLEGAL);

  // unlock rate limit
  // a wrong guess parks the sequencer for the full interval
  // the count sits at the nominal interval, well inside the tolerance band
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= slk_pkg::ST_IDLE;
      wait_cnt  <= '0;
      unlock_ok <= 1'b0;
      busy      <= 1'b0;
    end else if (clk_en) begin
      if (hw_rst) begin
        state     <= slk_pkg::ST_IDLE;
        wait_cnt  <= '0;
        unlock_ok <= 1'b0;
        busy      <= 1'b0;
      end else begin
        unique case (state)
          slk_pkg::ST_IDLE: begin
            if (cmd_go && op == slk_pkg::OP_UNLOCK && pw_mode) begin
              state     <= slk_pkg::ST_HOLD;
              busy      <= 1'b1;
              unlock_ok <= pwd_match;
              wait_cnt  <= pwd_match ? '0 : slk_pkg::CNT_W'(UNLOCK_CYC - 1);
            end
          end
          slk_pkg::ST_HOLD: begin
            if (wait_cnt == '0) begin
              state     <= slk_pkg::ST_IDLE;
              busy      <= 1'b0;
              unlock_ok <= 1'b0;
            end else begin
              wait_cnt <= wait_cnt - 1'b1;
            end
          end
        endcase
      end
    end
  end

  // lock bit, volatile; fresh power-up lands in blank mode
  // pin reset is checked first, so it beats an unlock ending in that cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lock <= 1'b1;
    end else if (clk_en) begin
      if (hw_rst) begin
        lock <= ~pw_mode;
      end else if (state == slk_pkg::ST_HOLD && wait_cnt == '0 && unlock_ok) begin
        lock <= 1'b1;
      end else if (cmd_go && op == slk_pkg::OP_LOCK_CLR) begin
        lock <= 1'b0;
      end
    end
  end

  // program error flag, sticky until cleared
  // soft reset leaves it; only the clear command, the pin reset or power-on drops it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      perr <= 1'b0;
    end else if (clk_en) begin
      if (hw_rst) begin
        perr <= 1'b0;
      end else if (cmd_go) begin
        unique case (op)
          slk_pkg::OP_UNLOCK: begin
            if (pw_mode && !pwd_match) begin
              perr <= 1'b1;
            end
          end
          slk_pkg::OP_PBIT_PROG,
          slk_pkg::OP_PBIT_ERASE: begin
            if (!lock) begin
              perr <= 1'b1;
            end
          end
          slk_pkg::OP_MODE_PROG: begin
            if (!mode_ok) begin
              perr <= 1'b1;
            end
          end
          // nothing can set the flag in this same cycle
          slk_pkg::OP_CLR_ERR: begin
            perr <= 1'b0;
          end
          default: begin
            perr <= perr;
          end
        endcase
      end
    end
  end

  // non-volatile store
  // only power-on restores factory state; other resets leave it
  // flops stand in for the array, so power-on here means factory state
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pbits <= slk_pkg::SECT_ALL_ONES;
      mode  <= slk_pkg::MODE_BLANK;
      pwd   <= slk_pkg::PWD_ERASED;
    end else if (clk_en && cmd_go) begin
      if (op == slk_pkg::OP_PBIT_PROG && lock) begin
        pbits[sect] <= 1'b0;
      end
      if (op == slk_pkg::OP_PBIT_ERASE && lock) begin
        pbits <= slk_pkg::SECT_ALL_ONES;
      end
      if (op == slk_pkg::OP_MODE_PROG && mode_ok) begin
        mode <= mode_new;
      end
      if (op == slk_pkg::OP_PWD_PROG && !pw_mode) begin
        pwd <= pwd & opnd;
      end
    end
  end

  // snapshot taken by the read command, so later programs stay hidden
  // password read path
  // read silently ignored in password mode
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pwd_rd <= '0;
    end else if (clk_en && cmd_go && op == slk_pkg::OP_PWD_READ && !pw_mode) begin
      pwd_rd <= pwd;
    end
  end

  // volatile sector bits
  // the only state that a soft reset touches
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      vbits <= slk_pkg::SECT_ALL_ONES;
    end else if (clk_en) begin
      if (hw_rst || (cmd_go && op == slk_pkg::OP_SOFT_RST)) begin
        vbits <= slk_pkg::SECT_ALL_ONES;
      end else if (cmd_go && op == slk_pkg::OP_VBIT_WR) begin
        vbits[sect] <= sval;
      end
    end
  end

  // operand, config and read address registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      opnd      <= '0;
      read_prot <= 1'b0;
      raddr     <= '0;
    end else if (wr_go) begin
      if (reg_addr == slk_pkg::OFS_OPND_LO) begin
        opnd[slk_pkg::DATA_W-1:0] <= reg_wdata;
      end
      if (reg_addr == slk_pkg::OFS_OPND_HI) begin
        opnd[slk_pkg::PWD_W-1:slk_pkg::DATA_W] <= reg_wdata;
      end
      if (reg_addr == slk_pkg::OFS_CONFIG) begin
        read_prot <= reg_wdata[slk_pkg::CFG_RDPROT_BIT];
      end
      if (reg_addr == slk_pkg::OFS_RADDR) begin
        raddr <= reg_wdata;
      end
    end
  end

  // status word for the bus
  // fields above the mode read as zero
  always_comb begin
    status           = '0;
    status.mode      = mode;
    status.read_prot = read_prot;
    status.lock      = lock;
    status.perr      = perr;
    status.busy      = busy;
  end

  // sector unprotected map
  // registered so the output comes from a flop, one cycle behind
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      unprot_map <= slk_pkg::SECT_ALL_ONES;
    end else if (clk_en) begin
      unprot_map <= pbits & vbits;
    end
  end

  // read data valid one cycle after the strobe, zero otherwise
  // an idle port reads zero while the enable is high; with the enable low the last read data is held
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= '0;
      if (rd_go) begin
        unique case (reg_addr)
          slk_pkg::OFS_STATUS: begin
            reg_rdata <= slk_pkg::DATA_W'(status);
          end
          slk_pkg::OFS_PBITS: begin
            reg_rdata <= pbits;
          end
          slk_pkg::OFS_VBITS: begin
            reg_rdata <= vbits;
          end
          slk_pkg::OFS_UNPROT: begin
            reg_rdata <= pbits & vbits;
          end
          slk_pkg::OFS_PWD_LO: begin
            reg_rdata <= pwd_rd[slk_pkg::DATA_W-1:0];
          end
          slk_pkg::OFS_PWD_HI: begin
            reg_rdata <= pwd_rd[slk_pkg::PWD_W-1:slk_pkg::DATA_W];
          end
          slk_pkg::OFS_CONFIG: begin
            reg_rdata <= slk_pkg::DATA_W'(read_prot);
          end
          slk_pkg::OFS_RADDR: begin
            reg_rdata <= read_prot ? slk_pkg::BOOT_ADDR : raddr;
          end
          default: begin
            // write-only and unmapped offsets read zero
            reg_rdata <= '0;
          end
        endcase
      end
    end
  end

endmodule // slk_sector_lock
`default_nettype wire

/* File: verif/slk_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module slk_monitor #(
  parameter int unsigned UNLOCK_CYC = slk_pkg::UNLOCK_WAIT_CYC
) (
  // clock and resets
  input wire logic                         mclk,
  input wire logic                         arst_n,
  input wire logic                         clk_en,
  input wire logic                         hw_reset_n,
  // register port
  input wire logic [slk_pkg::ADDR_W-1:0]   reg_addr,
  input wire logic [slk_pkg::DATA_W-1:0]   reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [slk_pkg::DATA_W-1:0]   reg_rdata,
  // protection state
  input wire logic                         lock,
  input wire logic                         busy,
  input wire logic [slk_pkg::NUM_SECT-1:0] unprot_map
);
  logic [4:0]                hw_hist;
  logic [slk_pkg::CNT_W-1:0] busy_run;
  logic                      hw_quiet;
  logic                      cmd_lc;
  logic                      cmd_unl;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // pin history covers the two-flop sync delay
  assign hw_quiet = hw_reset_n && (&hw_hist);
  assign cmd_lc = reg_wr && clk_en && reg_addr == slk_pkg::OFS_CMD
                  && reg_wdata[3:0] == slk_pkg::OP_LOCK_CLR;
  assign cmd_unl = reg_wr && clk_en && reg_addr == slk_pkg::OFS_CMD
                   && reg_wdata[3:0] == slk_pkg::OP_UNLOCK;
  // busy run length and reset pin history
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hw_hist <= 5'h1F;
      busy_run <= '0;
    end else begin
      hw_hist <= {hw_hist[3:0], hw_reset_n};
      busy_run <= busy ? busy_run + 1'b1 : '0;
    end
  end
  sequence s_hw_held;
    !hw_reset_n [*4];
  endsequence
  sequence s_hold_start;
    $rose(busy) ##1 busy;
  endsequence
  property p_rd_only;
    !$past(reg_rd) |-> reg_rdata == '0;
  endproperty
  property p_hw_hold;
    s_hw_held |=> !busy && $stable(lock);
  endproperty
  property p_lock_rise;
    $rose(lock) && hw_quiet |-> $fell(busy);
  endproperty
  property p_lock_fall;
    $fell(lock) && hw_quiet |-> $past(cmd_lc) || $past(cmd_lc, 2);
  endproperty
  property p_busy_start;
    $rose(busy) |-> $past(cmd_unl);
  endproperty
  property p_busy_len;
    $fell(busy) && hw_quiet |-> busy_run == 1 || busy_run == UNLOCK_CYC
                                 || busy_run == UNLOCK_CYC + 1;
  endproperty
  property p_busy_lock;
    busy && $past(busy) && hw_quiet |=> $stable(lock);
  endproperty
  property p_hold;
    s_hold_start |-> (busy || !hw_reset_n) [*8];
  endproperty
  a_rd_only: assert property (p_rd_only)
    else $error("read data outside the answer cycle");
  a_hw_hold: assert property (p_hw_hold)
    else $error("state moved during hardware reset");
  a_lock_rise: assert property (p_lock_rise)
    else $error("lock rose without busy falling");
  a_lock_fall: assert property (p_lock_fall)
    else $error("lock fell without lock clear");
  a_busy_start: assert property (p_busy_start)
    else $error("busy without unlock");
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");
  a_busy_lock: assert property (p_busy_lock)
    else $error("lock moved after failed unlock");
  a_hold: assert property (p_hold)
    else $error("rate limit hold too short");
endmodule // slk_monitor
`default_nettype wire

/* File: verif/slk_host.sv */
`timescale 1ns/10ps
`default_nettype none
module slk_host (
  // clock
  input wire logic                        mclk,
  // register port
  output var logic [slk_pkg::ADDR_W-1:0]  reg_addr,
  output var logic [slk_pkg::DATA_W-1:0]  reg_wdata,
  output var logic                        reg_wr,
  output var logic                        reg_rd,
  input wire logic [slk_pkg::DATA_W-1:0]  reg_rdata
);
  // bus idle from time zero
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle write strobe
  task automatic wr(input logic [slk_pkg::ADDR_W-1:0] a, input logic [slk_pkg::DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [slk_pkg::ADDR_W-1:0] a, output logic [slk_pkg::DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic wait_idle(output logic ok);
    logic [slk_pkg::DATA_W-1:0] s;
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++) begin
      rd(slk_pkg::OFS_STATUS, s);
      ok = (s[0] === 1'b0);
    end
  endtask
endmodule // slk_host
`default_nettype wire

/* File: verif/slk_sector_lock_test.sv */
`timescale 1ns/10ps
`default_nettype none
module slk_sector_lock_test;
  localparam int unsigned UCYC = 20;
  localparam logic [63:0] PW = 64'h1234_5678_9ABC_DEF0;
  logic                       mclk, arst_n, clk_en, hw_reset_n, reg_wr, reg_rd, lock, busy, ok;
  logic [slk_pkg::ADDR_W-1:0] reg_addr;
  logic [31:0]                reg_wdata, reg_rdata, unprot_map;
  int                         num_errors, checks_done;
  slk_sector_lock #(.UNLOCK_CYC(UCYC)) uut (
    .mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .hw_reset_n(hw_reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lock(lock), .busy(busy), .unprot_map(unprot_map));
  slk_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // free running clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic rdc(input logic [slk_pkg::ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] d;
    host.rd(a, d);
    chk(e, d);
  endtask
  task automatic cmd(input slk_pkg::slk_op_t op, input logic [4:0] s, input logic v);
    host.wr(slk_pkg::OFS_CMD, {15'h0, v, 3'h0, s, 4'h0, op});
  endtask
  task automatic opnd(input logic [63:0] v);
    host.wr(slk_pkg::OFS_OPND_LO, v[31:0]);
    host.wr(slk_pkg::OFS_OPND_HI, v[63:32]);
  endtask
  // expected status word, read protection off
  function automatic logic [31:0] st(input logic [1:0] m, input logic l, input logic p);
    return {26'h0, m, 1'b0, l, p, 1'b0};
  endfunction
  task automatic pulse_rst(input bit hw);
    @(posedge mclk);
    if (hw) hw_reset_n <= 1'b0;
    else arst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    hw_reset_n <= 1'b1;
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  // blank mode acts persistent
  task automatic t_blank;
    rdc(slk_pkg::OFS_STATUS, st(2'h3, 1'b1, 1'b0)); // start
    cmd(slk_pkg::OP_PWD_READ, 5'd0, 1'b0); // snapshot
    rdc(slk_pkg::OFS_PWD_LO, 32'hFFFF_FFFF); // erased
    rdc(slk_pkg::OFS_PWD_HI, 32'hFFFF_FFFF); // erased high
    rdc(8'h3C, 32'h0000_0000);
    cmd(slk_pkg::OP_PBIT_PROG, 5'd3, 1'b0);
    cmd(slk_pkg::OP_VBIT_WR, 5'd5, 1'b0);
    rdc(slk_pkg::OFS_UNPROT, 32'hFFFF_FFD7); // map
    chk(32'hFFFF_FFD7, unprot_map); // port map
    cmd(slk_pkg::OP_LOCK_CLR, 5'd0, 1'b0);
    cmd(slk_pkg::OP_PBIT_PROG, 5'd7, 1'b0);
    cmd(slk_pkg::OP_PBIT_ERASE, 5'd0, 1'b0);
    rdc(slk_pkg::OFS_PBITS, 32'hFFFF_FFF7); // frozen
    cmd(slk_pkg::OP_VBIT_WR, 5'd5, 1'b1);
    rdc(slk_pkg::OFS_VBITS, 32'hFFFF_FFFF); // still free
    cmd(slk_pkg::OP_UNLOCK, 5'd0, 1'b0);
    cmd(slk_pkg::OP_VBIT_WR, 5'd9, 1'b0);
    cmd(slk_pkg::OP_SOFT_RST, 5'd0, 1'b0);
    rdc(slk_pkg::OFS_VBITS, 32'hFFFF_FFFF); // soft reset
    @(posedge mclk);
    clk_en <= 1'b0;
    cmd(slk_pkg::OP_VBIT_WR, 5'd1, 1'b0); // enable low
    clk_en <= 1'b1;
    rdc(slk_pkg::OFS_VBITS, 32'hFFFF_FFFF); // frozen write lost
    rdc(slk_pkg::OFS_STATUS, st(2'h3, 1'b0, 1'b1)); // lock low
    pulse_rst(1'b1);
    rdc(slk_pkg::OFS_STATUS, st(2'h3, 1'b1, 1'b0)); // hardware reset
    rdc(slk_pkg::OFS_PBITS, 32'hFFFF_FFF7); // retained
  endtask
  // password store, mode lock, unlock
  task automatic t_pwd;
    opnd(PW);
    cmd(slk_pkg::OP_PWD_PROG, 5'd0, 1'b0);
    opnd(64'hFFFF_FFFF_FFFF_FFFF);
    cmd(slk_pkg::OP_PWD_PROG, 5'd0, 1'b0);
    cmd(slk_pkg::OP_PWD_READ, 5'd0, 1'b0); // snapshot
    rdc(slk_pkg::OFS_PWD_LO, PW[31:0]); // low half
    rdc(slk_pkg::OFS_PWD_HI, PW[63:32]); // high half
    opnd(64'h0);
    cmd(slk_pkg::OP_MODE_PROG, 5'd0, 1'b0);
    rdc(slk_pkg::OFS_STATUS, st(2'h3, 1'b1, 1'b1)); // illegal mode
    cmd(slk_pkg::OP_CLR_ERR, 5'd0, 1'b0);
    opnd(64'h1);
    cmd(slk_pkg::OP_MODE_PROG, 5'd0, 1'b0);
    opnd(64'h2);
    cmd(slk_pkg::OP_MODE_PROG, 5'd0, 1'b0);
    rdc(slk_pkg::OFS_STATUS, st(2'h1, 1'b1, 1'b1)); // mode kept
    cmd(slk_pkg::OP_CLR_ERR, 5'd0, 1'b0);
    pulse_rst(1'b1);
    rdc(slk_pkg::OFS_STATUS, st(2'h1, 1'b0, 1'b0)); // locked
    opnd(64'h0);
    cmd(slk_pkg::OP_PWD_PROG, 5'd0, 1'b0);
    opnd(PW ^ 64'h1);
    cmd(slk_pkg::OP_UNLOCK, 5'd0, 1'b0);
    #1;
    chk(32'h1, {31'h0, busy}); // busy
    host.wait_idle(ok);
    chk(32'h1, {31'h0, ok}); // ends
    rdc(slk_pkg::OFS_STATUS, st(2'h1, 1'b0, 1'b1)); // failed
    cmd(slk_pkg::OP_CLR_ERR, 5'd0, 1'b0);
    cmd(slk_pkg::OP_PBIT_PROG, 5'd2, 1'b0);
    rdc(slk_pkg::OFS_PBITS, 32'hFFFF_FFFF); // refused
    rdc(slk_pkg::OFS_STATUS, st(2'h1, 1'b0, 1'b1)); // error flag
    cmd(slk_pkg::OP_CLR_ERR, 5'd0, 1'b0);
    opnd(PW);
    cmd(slk_pkg::OP_UNLOCK, 5'd0, 1'b0);
    host.wait_idle(ok);
    cmd(slk_pkg::OP_SOFT_RST, 5'd0, 1'b0);
    rdc(slk_pkg::OFS_STATUS, st(2'h1, 1'b1, 1'b0)); // open
    cmd(slk_pkg::OP_LOCK_CLR, 5'd0, 1'b0);
    host.wr(slk_pkg::OFS_RADDR, 32'h0000_1234);
    rdc(slk_pkg::OFS_RADDR, 32'h0000_1234); // plain
    host.wr(slk_pkg::OFS_CONFIG, 32'h0000_0001);
    rdc(slk_pkg::OFS_RADDR, slk_pkg::BOOT_ADDR); // forced
    rdc(slk_pkg::OFS_STATUS, st(2'h1, 1'b0, 1'b0) | 32'h0000_0008); // flags
  endtask
  task automatic complete_run;
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    hw_reset_n = 1'b1;
    num_errors = 0;
    checks_done = 0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_blank;
    pulse_rst(1'b0);
    t_pwd;
    complete_run;
  end
  // watchdog well past the expected run
  initial begin
    #100000;
    num_errors++;
    complete_run;
  end
endmodule // slk_sector_lock_test
bind slk_sector_lock slk_monitor #(.UNLOCK_CYC(UNLOCK_CYC)) mon (
  .mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .hw_reset_n(hw_reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .lock(lock), .busy(busy), .unprot_map(unprot_map));
`default_nettype wire
